// ---- adcs_defs.vh ----
// Overview of operation
// - every conversion result is kept and reported as an 8-bit value
// - single-step converts one selected channel per start, then advances the counter
// - timer event or chosen pin edge generates the start condition itself
// - scan mode converts all selected channels on one start, no further starts
// - single-step, several channels: clearing boundary flag mid-sequence returns counter to lowest
// - trigger-started repeating scans restart at the lowest channel on every trigger
// - disabling then enabling the converter returns the counter to its start
// - switching to DAC mode and back also resets the channel counter
// - two independent converters with identical sequencing behaviour
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH
`define ADCS_AW 6
`define ADCS_RES_W 8
`define ADCS_NCH 4
// per converter register index, converter select is address bit 4
`define ADCS_REG_MODE 4'h0
`define ADCS_REG_SEL 4'h1
`define ADCS_REG_LO 4'h2
`define ADCS_REG_HI 4'h3
`define ADCS_REG_RES0 4'h4
`define ADCS_CONV1_BIT 4
`define ADCS_REG_STAT 6'h20
`define ADCS_REG_MASK 6'h21
// mode register fields
`define ADCS_M_EN 0
`define ADCS_M_DAC 1
`define ADCS_M_SCAN 2
`define ADCS_M_TRIG_LO 3
`define ADCS_M_START 5
`define ADCS_M_BND 6
`define ADCS_M_BUSY 7
// trigger sources
`define ADCS_TRIG_SW 2'h0
`define ADCS_TRIG_TMR 2'h1
`define ADCS_TRIG_RISE 2'h2
`define ADCS_TRIG_FALL 2'h3
// status bits: {done1, bnd1, done0, bnd0}
`define ADCS_STAT_W 4
`define ADCS_RST_LO 8'h00
`define ADCS_RST_HI 8'hff
`endif

// ---- adcs_seq.v ----
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "adcs_defs.vh"

module adcs_conv #(
  parameter NCH = `ADCS_NCH,
  parameter RW = `ADCS_RES_W
) (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire [7:0] wdata,
  input wire wr_mode,
  input wire wr_sel,
  input wire wr_lo,
  input wire wr_hi,
  input wire timer_evt,
  input wire trig_pin,
  input wire conv_done,
  input wire [RW-1:0] conv_data,
  output reg conv_start_ff,
  output reg [1:0] conv_ch_ff,
  output wire [7:0] mode_rd,
  output reg [NCH-1:0] sel_ff,
  output reg [RW-1:0] lo_ff,
  output reg [RW-1:0] hi_ff,
  output wire [NCH*RW-1:0] res_flat,
  output reg bnd_evt_ff,
  output reg done_evt_ff
);
  reg en_ff;
  reg dac_ff;
  reg scan_ff;
  reg [1:0] trig_ff;
  reg bnd_ff;
  reg busy_ff;
  reg pin_ff;
  reg [1:0] cur_ff;
  reg [RW-1:0] res_ff [0:NCH-1];
  wire [1:0] low_ch;
  wire [2:0] nx;
  wire [1:0] pick_ch;
  wire multi;
  reg start;
  genvar g;

  function [1:0] lowest_sel;
    input [NCH-1:0] s;
    integer i;
    begin
      lowest_sel = 2'h0;
      for (i = NCH - 1; i >= 0; i = i - 1)
        if (s[i])
          lowest_sel = i[1:0];
    end
  endfunction

  // returns {wrapped, next selected channel above c}
  function [2:0] next_sel;
    input [NCH-1:0] s;
    input [1:0] c;
    integer i;
    reg found;
    begin
      found = 1'b0;
      next_sel = {1'b1, lowest_sel(s)};
      for (i = 0; i < NCH; i = i + 1)
        if (!found && s[i] && i > c) begin
          found = 1'b1;
          next_sel = {1'b0, i[1:0]};
        end
    end
  endfunction

  assign low_ch = lowest_sel(sel_ff);
  assign nx = next_sel(sel_ff, conv_ch_ff);
  assign pick_ch = sel_ff[cur_ff] ? cur_ff : low_ch;
  assign multi = (sel_ff & (sel_ff - 1'b1)) != {NCH{1'b0}};
  assign mode_rd = {busy_ff, bnd_ff, 1'b0, trig_ff, scan_ff, dac_ff, en_ff};

  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_res
      assign res_flat[g*RW +: RW] = res_ff[g];
    end
  endgenerate

  // start from software write, timer or pin edge
  always @* begin
    case (trig_ff)
      `ADCS_TRIG_TMR: start = timer_evt;
      `ADCS_TRIG_RISE: start = trig_pin & ~pin_ff;
      `ADCS_TRIG_FALL: start = ~trig_pin & pin_ff;
      default: start = wr_mode & wdata[`ADCS_M_START];
    endcase
  end

  integer k;
  always @(posedge core_clk) begin
    if (!nrst) begin
      en_ff <= 1'b0;
      dac_ff <= 1'b0;
      scan_ff <= 1'b0;
      trig_ff <= `ADCS_TRIG_SW;
      bnd_ff <= 1'b0;
      busy_ff <= 1'b0;
      pin_ff <= 1'b0;
      cur_ff <= 2'h0;
      sel_ff <= {NCH{1'b0}};
      lo_ff <= `ADCS_RST_LO;
      hi_ff <= `ADCS_RST_HI;
      conv_start_ff <= 1'b0;
      conv_ch_ff <= 2'h0;
      bnd_evt_ff <= 1'b0;
      done_evt_ff <= 1'b0;
      for (k = 0; k < NCH; k = k + 1)
        res_ff[k] <= {RW{1'b0}};
    end else if (ce) begin
      pin_ff <= trig_pin;
      conv_start_ff <= 1'b0;
      bnd_evt_ff <= 1'b0;
      done_evt_ff <= 1'b0;
      if (wr_mode) begin
        en_ff <= wdata[`ADCS_M_EN];
        dac_ff <= wdata[`ADCS_M_DAC];
        scan_ff <= wdata[`ADCS_M_SCAN];
        trig_ff <= wdata[`ADCS_M_TRIG_LO +: 2];
        if (!wdata[`ADCS_M_BND])
          bnd_ff <= 1'b0;
      end
      if (wr_sel)
        sel_ff <= wdata[NCH-1:0];
      if (wr_lo)
        lo_ff <= wdata;
      if (wr_hi)
        hi_ff <= wdata;
      if (!en_ff || dac_ff) begin
        cur_ff <= low_ch;
        busy_ff <= 1'b0;
      end else if (!busy_ff && start && sel_ff != {NCH{1'b0}}) begin
        busy_ff <= 1'b1;
        conv_start_ff <= 1'b1;
        if (scan_ff) begin
          conv_ch_ff <= low_ch;
          cur_ff <= low_ch;
        end else begin
          conv_ch_ff <= pick_ch;
          cur_ff <= pick_ch;
        end
      end else if (busy_ff && conv_done) begin
        res_ff[conv_ch_ff] <= conv_data;
        // boundary check, set wins over clear
        if (conv_data < lo_ff || conv_data > hi_ff) begin
          bnd_ff <= 1'b1;
          bnd_evt_ff <= 1'b1;
        end
        if (scan_ff && !nx[2]) begin
          conv_start_ff <= 1'b1;
          conv_ch_ff <= nx[1:0];
          cur_ff <= nx[1:0];
        end else begin
          busy_ff <= 1'b0;
          cur_ff <= nx[1:0];
          if (scan_ff || nx[2])
            done_evt_ff <= 1'b1;
        end
      end
      if (wr_mode && !wdata[`ADCS_M_BND] && bnd_ff && !scan_ff && multi && cur_ff != low_ch && !busy_ff)
        cur_ff <= low_ch;
    end
  end
endmodule // adcs_conv

module adcs_seq #(
  parameter NCH = `ADCS_NCH,
  parameter RW = `ADCS_RES_W
) (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire [`ADCS_AW-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_ff,
  input wire [1:0] timer_evt,
  input wire [1:0] trig_pin,
  input wire [1:0] conv_done,
  input wire [2*RW-1:0] conv_data,
  output wire [1:0] conv_start,
  output wire [3:0] conv_ch,
  output wire irq
);
  reg [`ADCS_STAT_W-1:0] stat_ff;
  reg [`ADCS_STAT_W-1:0] mask_ff;
  wire [15:0] mode_rd;
  wire [2*NCH-1:0] sel_rd;
  wire [2*RW-1:0] lo_rd;
  wire [2*RW-1:0] hi_rd;
  wire [2*NCH*RW-1:0] res_rd;
  wire [1:0] bnd_evt;
  wire [1:0] done_evt;
  wire [`ADCS_STAT_W-1:0] evt;
  wire per_conv;
  wire cs;
  reg [7:0] nxt_rdata;
  genvar g;

  assign per_conv = addr[`ADCS_AW-1] == 1'b0;
  assign cs = addr[`ADCS_CONV1_BIT];
  assign evt = {done_evt[1], bnd_evt[1], done_evt[0], bnd_evt[0]};
  assign irq = |(stat_ff & mask_ff);

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_conv
      wire hit;
      assign hit = wr && per_conv && cs == g;
      adcs_conv #(.NCH(NCH), .RW(RW)) u_conv (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .wdata(wdata),
        .wr_mode(hit && addr[3:0] == `ADCS_REG_MODE),
        .wr_sel(hit && addr[3:0] == `ADCS_REG_SEL),
        .wr_lo(hit && addr[3:0] == `ADCS_REG_LO),
        .wr_hi(hit && addr[3:0] == `ADCS_REG_HI),
        .timer_evt(timer_evt[g]),
        .trig_pin(trig_pin[g]),
        .conv_done(conv_done[g]),
        .conv_data(conv_data[g*RW +: RW]),
        .conv_start_ff(conv_start[g]),
        .conv_ch_ff(conv_ch[g*2 +: 2]),
        .mode_rd(mode_rd[g*8 +: 8]),
        .sel_ff(sel_rd[g*NCH +: NCH]),
        .lo_ff(lo_rd[g*RW +: RW]),
        .hi_ff(hi_rd[g*RW +: RW]),
        .res_flat(res_rd[g*NCH*RW +: NCH*RW]),
        .bnd_evt_ff(bnd_evt[g]),
        .done_evt_ff(done_evt[g])
      );
    end
  endgenerate

  always @* begin
    nxt_rdata = 8'h00;
    if (per_conv) begin
      case (addr[3:0])
        `ADCS_REG_MODE: nxt_rdata = mode_rd[cs*8 +: 8];
        `ADCS_REG_SEL: nxt_rdata = {{(8-NCH){1'b0}}, sel_rd[cs*NCH +: NCH]};
        `ADCS_REG_LO: nxt_rdata = lo_rd[cs*RW +: RW];
        `ADCS_REG_HI: nxt_rdata = hi_rd[cs*RW +: RW];
        4'h4, 4'h5, 4'h6, 4'h7: nxt_rdata = res_rd[(cs*NCH + addr[1:0])*RW +: RW];
        default: nxt_rdata = 8'h00;
      endcase
    end else if (addr == `ADCS_REG_STAT) begin
      nxt_rdata = {4'h0, stat_ff};
    end else if (addr == `ADCS_REG_MASK) begin
      nxt_rdata = {4'h0, mask_ff};
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      stat_ff <= 4'h0;
      mask_ff <= 4'h0;
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= rd ? nxt_rdata : 8'h00;
      if (wr && addr == `ADCS_REG_MASK)
        mask_ff <= wdata[`ADCS_STAT_W-1:0];
      // sticky event, set wins over clear
      if (wr && addr == `ADCS_REG_STAT)
        stat_ff <= (stat_ff & ~wdata[`ADCS_STAT_W-1:0]) | evt;
      else
        stat_ff <= stat_ff | evt;
    end
  end
endmodule // adcs_seq

// ---- adcs_chk_asserts.sv ----
`timescale 1ns/100ps
module adcs_chk (
  input wire core_clk,
  input wire nrst,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata_ff,
  input wire [1:0] timer_evt,
  input wire [1:0] trig_pin,
  input wire [1:0] conv_done,
  input wire [1:0] conv_start,
  input wire [3:0] conv_ch,
  input wire irq
);
  reg [1:0] pin_ff;
  reg [1:0] bz_ff;
  wire cause = wr | timer_evt[0] | conv_done[0] | (trig_pin[0] ^ pin_ff[0]);
  // one conversion in flight per converter, freed by its done
  always @(posedge core_clk) begin
    pin_ff <= nrst ? trig_pin : 2'h0;
    bz_ff <= nrst ? (bz_ff | conv_start) & ~conv_done : 2'h0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_cause;
    $past(cause) || $past(cause, 2) || $past(cause, 3);
  endsequence
  property p_cause; conv_start[0] |-> s_cause; endproperty
  a_cause: assert property (p_cause) else $error("start without cause");
  property p_pulse; conv_start[0] |=> !conv_start[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_one0; conv_start[0] |-> !bz_ff[0]; endproperty
  a_one0: assert property (p_one0) else $error("start while busy");
  property p_one1; conv_start[1] |-> !bz_ff[1]; endproperty
  a_one1: assert property (p_one1) else $error("start while busy");
  property p_hold; $changed(conv_ch[1:0]) |-> conv_start[0]; endproperty
  a_hold: assert property (p_hold) else $error("channel moved");
  property p_fall; $fell(irq) |-> $past(wr) || $past(wr, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
  property p_rise; $rose(irq) |-> $past(|conv_done) || $past(|conv_done, 2) || $past(wr) || $past(wr, 2); endproperty
  a_rise: assert property (p_rise) else $error("irq raised alone");
  property p_rdz; !$past(rd) |-> rdata_ff == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data out of slot");
endmodule // adcs_chk
bind adcs_seq adcs_chk u_adcs_chk (.core_clk(core_clk), .nrst(nrst), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
  .timer_evt(timer_evt), .trig_pin(trig_pin), .conv_done(conv_done), .conv_start(conv_start), .conv_ch(conv_ch),
  .irq(irq));

// ---- adcs_ana.sv ----
`timescale 1ns/100ps
module adcs_ana (
  input wire core_clk,
  input wire nrst,
  input wire slow,
  input wire [1:0] conv_start,
  input wire [3:0] conv_ch,
  output reg [1:0] conv_done = 2'h0,
  output reg [15:0] conv_data = 16'h0000
);
  reg [3:0] cnt [0:1];
  reg [1:0] chq [0:1];
  integer i;
  // data toggles outside the done cycle so a late sample never matches
  always @(posedge core_clk) begin
    for (i = 0; i < 2; i = i + 1) begin
      conv_done[i] <= 1'b0;
      conv_data[8*i +: 8] <= ~conv_data[8*i +: 8];
      if (!nrst) begin
        cnt[i] <= 4'h0;
      end else if (conv_start[i]) begin
        cnt[i] <= slow ? 4'h7 : 4'h2;
        chq[i] <= conv_ch[2*i +: 2];
      end else if (cnt[i] == 4'h1) begin
        cnt[i] <= 4'h0;
        conv_done[i] <= 1'b1;
        conv_data[8*i +: 8] <= {chq[i], 5'h02, i[0]};
      end else if (cnt[i] != 4'h0) begin
        cnt[i] <= cnt[i] - 4'h1;
      end
    end
  end
endmodule // adcs_ana

// ---- test_adcs_seq.sv ----
`timescale 1ns/100ps
module test_adcs_seq;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg wr = 1'b0, rd = 1'b0, slow = 1'b0, ce = 1'b1;
  reg [5:0] addr = 6'h00;
  reg [7:0] wdata = 8'h00;
  reg [1:0] timer_evt = 2'h0, trig_pin = 2'h0;
  wire [7:0] rdata_ff;
  wire [1:0] conv_done, conv_start;
  wire [15:0] conv_data;
  wire [3:0] conv_ch;
  wire irq;
  integer fails = 0, n_checks = 0, k, j;
  always #2.5 core_clk = ~core_clk;
  adcs_seq u_adcs_seq (.core_clk(core_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .timer_evt(timer_evt), .trig_pin(trig_pin), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start(conv_start), .conv_ch(conv_ch), .irq(irq));
  adcs_ana u_adcs_ana (.core_clk(core_clk), .nrst(nrst), .slow(slow), .conv_start(conv_start),
    .conv_ch(conv_ch), .conv_done(conv_done), .conv_data(conv_data));
  task end_sim;
  begin
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input string w, input [7:0] e, input [7:0] g);
  begin
    n_checks = n_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("Error %s exp %h got %h", w, e, g);
    end
  end
  endtask
  task wreg(input [5:0] a, input [7:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  task rreg(input [5:0] a, output [7:0] g);
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    g = rdata_ff;
  end
  endtask
  task rchk(input [5:0] a, input [7:0] e);
    reg [7:0] g;
  begin
    rreg(a, g);
    chk($sformatf("reg %h", a), e, g);
  end
  endtask
  // polls busy with a bound, then checks it cleared
  task idle(input [5:0] a);
    reg [7:0] g;
    integer n;
  begin
    g = 8'h80;
    for (n = 0; n < 40 && g[7]; n = n + 1)
      rreg(a, g);
    chk("busy", 8'h00, {7'h0, g[7]});
  end
  endtask
  initial begin
    #100000;
    fails = fails + 1;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rchk(6'h02, 8'h00);
    rchk(6'h13, 8'hff);
    rchk(6'h3f, 8'h00);
    wreg(6'h21, 8'h01);
    wreg(6'h01, 8'h05);
    // enable first: a start written beside the enable bit is not taken
    wreg(6'h00, 8'h01);
    for (k = 0; k < 2; k = k + 1) begin
      wreg(6'h00, 8'h21);
      idle(6'h00);
      chk("ch", {k[6:0], 1'b0}, {6'h0, conv_ch[1:0]});
      rchk(6'h04 + {k[4:0], 1'b0}, {k[0], 7'h04});
      rchk(6'h20, {6'h0, k[0], 1'b0});
    end
    wreg(6'h20, 8'h0f);
    wreg(6'h03, 8'h03);
    wreg(6'h01, 8'h07);
    wreg(6'h00, 8'h21);
    idle(6'h00);
    chk("irq", 8'h01, {7'h0, irq});
    rchk(6'h00, 8'h41);
    wreg(6'h00, 8'h01);
    wreg(6'h00, 8'h21);
    idle(6'h00);
    chk("ch", 8'h00, {6'h0, conv_ch[1:0]});
    wreg(6'h00, 8'h61);
    idle(6'h00);
    chk("ch", 8'h01, {6'h0, conv_ch[1:0]});
    for (k = 0; k < 3; k = k + 1) begin
      wreg(k == 2 ? 6'h20 : 6'h21, {7'h0, k[0] | k[1]});
      @(posedge core_clk);
      chk("irq", {7'h0, k[0]}, {7'h0, irq});
    end
    wreg(6'h03, 8'hff);
    wreg(6'h11, 8'h09);
    wreg(6'h10, 8'h05);
    wreg(6'h10, 8'h25);
    idle(6'h10);
    chk("ch1", 8'h03, {6'h0, conv_ch[3:2]});
    rchk(6'h14, 8'h05);
    rchk(6'h17, 8'hc5);
    rchk(6'h20, 8'h08);
    slow <= 1'b1;
    wreg(6'h01, 8'h06);
    for (k = 0; k < 6; k = k + 1) begin
      wreg(6'h00, {3'h0, k[2:1] + 2'h1, 3'h5});
      if (k < 2)
        timer_evt[0] <= 1'b1;
      else
        trig_pin[0] <= 1'b1;
      @(posedge core_clk);
      timer_evt <= 2'h0;
      trig_pin <= 2'h0;
      for (j = 0; j < 20 && conv_start[0] !== 1'b1; j = j + 1)
        @(posedge core_clk);
      chk("start", 8'h01, {7'h0, conv_start[0]});
      chk("ch", 8'h01, {6'h0, conv_ch[1:0]});
      idle(6'h00);
    end
    slow <= 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      for (j = 0; j < 2; j = j + 1) begin
        wreg(6'h00, k ? 8'h03 : 8'h00);
        wreg(6'h00, 8'h01);
        wreg(6'h00, 8'h21);
        idle(6'h00);
      end
      chk("ch", 8'h01, {6'h0, conv_ch[1:0]});
    end
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wreg(6'h02, 8'h55);
    ce <= 1'b1;
    rchk(6'h02, 8'h00);
    end_sim;
  end
endmodule // test_adcs_seq
